// File: verilog/apgc_defines.svh
// Constants for the front-end power mode and gain control block.
// Assumes inclusion by bare name from the package and the modules.
`ifndef APGC_DEFINES_SVH
`define APGC_DEFINES_SVH

`define APGC_NUM_CH          2
`define APGC_GAIN_W          3
`define APGC_LOG2_GAIN_W     3
`define APGC_PD_ALL          2'h3
`define APGC_REF_CLK_MHZ     200
`define APGC_MCLK_MHZ        4
`define APGC_SAMPLE_MHZ      1
`define APGC_MCLK_DIV        (`APGC_REF_CLK_MHZ / `APGC_MCLK_MHZ)
`define APGC_SAMPLE_DIV      (`APGC_MCLK_MHZ / `APGC_SAMPLE_MHZ)
`define APGC_NUM_COMP        4
`define APGC_DAC_LEVELS      5
`define APGC_THERM_RESET     4'h3
`define APGC_LEVEL_RESET     3'h2

`endif

// File: verilog/apgc_pkg.sv
// Types for the front-end power mode and gain control block.
// Assumes the defines header is on the include path.
`include "apgc_defines.svh"

package apgc_pkg;
    typedef logic [`APGC_GAIN_W-1:0]      apgc_gain_sel_t;
    typedef logic [`APGC_LOG2_GAIN_W-1:0] apgc_log2_gain_t;
    typedef logic [`APGC_NUM_COMP-1:0]    apgc_therm_t;
    typedef logic [2:0]                   apgc_level_t;
    typedef enum logic [1:0] {
        APGC_RUN,
        APGC_PART_OFF,
        APGC_FULL_OFF
    } apgc_mode_t;
endpackage : apgc_pkg

// File: verilog/apgc_chan.sv
// One converter channel: gain decode, quantizer coding and output gating.
// Assumes sample_tick is a one-cycle pulse on ref_clk.
`timescale 1ns/1ps
`include "apgc_defines.svh"

module apgc_chan #(
    parameter int DATA_W = 24
) (
    // Clock and reset
    input  wire logic                    ref_clk,
    input  wire logic                    resetn,
    input  wire logic                    clk_en,
    // Control
    input  wire logic                    power_down,
    input  wire apgc_pkg::apgc_gain_sel_t channel_gain_select,
    input  wire logic                    sample_tick,
    // Quantizer and result input
    input  wire apgc_pkg::apgc_therm_t   comp_in,
    input  wire logic [DATA_W-1:0]       result_in,
    input  wire logic                    result_valid,
    // Outputs
    output logic                         chan_enable,
    output apgc_pkg::apgc_log2_gain_t    gain_log2,
    output apgc_pkg::apgc_therm_t        therm_code,
    output apgc_pkg::apgc_level_t        dac_level,
    output logic [DATA_W-1:0]            data_out,
    output logic                         data_ready
);
    import apgc_pkg::*;

    // ----------------------------------------------------------------
    // Gain decode
    // ----------------------------------------------------------------
    // Gain code mapping
    function automatic apgc_log2_gain_t gain_decode(input apgc_gain_sel_t sel);
        if (sel <= 3'h5) begin
            gain_decode = sel;
        end else begin
            gain_decode = 3'h0;
        end
    endfunction : gain_decode

    // Thermometer to level count, one per asserted comparator
    function automatic apgc_level_t therm_level(input apgc_therm_t t);
        apgc_level_t n;
        n = 3'h0;
        for (int i = 0; i < `APGC_NUM_COMP; i++) begin
            n = n + {2'h0, t[i]};
        end
        therm_level = n;
    endfunction : therm_level

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    apgc_log2_gain_t   gain_ff,  nxt_gain;
    apgc_therm_t       therm_ff, nxt_therm;
    apgc_level_t       level_ff, nxt_level;
    logic [DATA_W-1:0] data_ff,  nxt_data;
    logic              rdy_ff,   nxt_rdy;

    always_comb begin
        nxt_gain  = gain_ff;
        nxt_therm = therm_ff;
        nxt_level = level_ff;
        nxt_data  = data_ff;
        nxt_rdy   = 1'b0;
        if (clk_en) begin
            nxt_gain = gain_decode(channel_gain_select);
            if (power_down) begin
                nxt_data  = '0;
                nxt_therm = `APGC_THERM_RESET;
                nxt_level = therm_level(`APGC_THERM_RESET);
            end else begin
                if (sample_tick) begin
                    nxt_therm = comp_in;
                    nxt_level = therm_level(comp_in);
                end
                if (result_valid) begin
                    nxt_data = result_in;
                    nxt_rdy  = 1'b1;
                end
            end
        end else begin
            nxt_rdy = rdy_ff;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            gain_ff  <= 3'h0;
            therm_ff <= `APGC_THERM_RESET;
            level_ff <= `APGC_LEVEL_RESET;
            data_ff  <= '0;
            rdy_ff   <= 1'b0;
        end else begin
            gain_ff  <= nxt_gain;
            therm_ff <= nxt_therm;
            level_ff <= nxt_level;
            data_ff  <= nxt_data;
            rdy_ff   <= nxt_rdy;
        end
    end

    assign chan_enable = ~power_down;
    assign gain_log2   = gain_ff;
    assign therm_code  = therm_ff;
    assign dac_level   = level_ff;
    assign data_out    = data_ff;
    assign data_ready  = rdy_ff;
endmodule : apgc_chan

// File: verilog/apgc_top.sv
// Power mode sequencing and gain control for a two-channel converter front end.
// Assumes control bits come from the serial register logic on ref_clk.
//
// Functional notes
// - Full low power is entered only when both power-down bits and both external selects are set.
// - In full low power both supply monitors are off and no clock propagates.
// - In full low power every converter is off and the internal reference is off.
// - Full low power is possible only in serial-register mode, never in two-wire mode.
// - In full low power the input sampling structure gets no clock.
// - The serial interface stays enabled in full low power.
// - Clearing any of the four control bits re-enables both supply monitors.
// - Each channel has its own 3-bit gain field.
// - Gain codes 0 to 5 select gains 1, 2, 4, 8, 16 and 32.
// - Gain codes 6 and 7 give a gain of 1.
// - The quantizer is four comparators with thermometer output.
// - The feedback converter has five levels.
// - Each modulator updates once per sample clock, master clock divided by four.
// - Each channel powers down independently via its own bit.
// - Power-down bits sit in the primary setup register, writable only in serial mode.
// - A powered-down channel reads zero data and gives no data-ready.
`timescale 1ns/1ps
`include "apgc_defines.svh"

module apgc_top #(
    parameter int DATA_W   = 24,
    parameter int MCLK_DIV = `APGC_MCLK_DIV,
    parameter int SMP_DIV  = `APGC_SAMPLE_DIV
) (
    // Clock, reset, enable
    input  wire logic                         ref_clk,
    input  wire logic                         resetn,
    input  wire logic                         clk_en,
    // Setup bits
    input  wire logic                         spi_mode,
    input  wire logic [1:0]                   setup_pd_wdata,
    input  wire logic                         setup_pd_we,
    input  wire logic                         external_clock_select,
    input  wire logic                         external_reference_select,
    input  wire apgc_pkg::apgc_gain_sel_t     channel_gain_select_0,
    input  wire apgc_pkg::apgc_gain_sel_t     channel_gain_select_1,
    // Converter inputs
    input  wire apgc_pkg::apgc_therm_t        comp_in_0,
    input  wire apgc_pkg::apgc_therm_t        comp_in_1,
    input  wire logic [DATA_W-1:0]            result_in_0,
    input  wire logic [DATA_W-1:0]            result_in_1,
    input  wire logic                         result_valid_0,
    input  wire logic                         result_valid_1,
    // Power gating
    output logic                              full_low_power,
    output logic                              avdd_monitor_en,
    output logic                              dvdd_monitor_en,
    output logic                              int_ref_en,
    output logic                              clock_dist_en,
    output logic                              input_clock_en,
    output logic                              spi_enable,
    output logic [1:0]                        setup_pd,
    output logic [1:0]                        chan_enable,
    output apgc_pkg::apgc_mode_t              power_mode,
    // Clocks
    output logic                              mclk_tick,
    output logic                              modulator_sample_clock,
    // Channel outputs
    output apgc_pkg::apgc_log2_gain_t         gain_log2_0,
    output apgc_pkg::apgc_log2_gain_t         gain_log2_1,
    output apgc_pkg::apgc_therm_t             therm_code_0,
    output apgc_pkg::apgc_therm_t             therm_code_1,
    output apgc_pkg::apgc_level_t             dac_level_0,
    output apgc_pkg::apgc_level_t             dac_level_1,
    output logic [DATA_W-1:0]                 data_out_0,
    output logic [DATA_W-1:0]                 data_out_1,
    output logic [1:0]                        data_ready
);
    import apgc_pkg::*;

    // ----------------------------------------------------------------
    // Primary setup register power-down bits
    // ----------------------------------------------------------------
    logic [1:0] pd_ff, nxt_pd;

    always_comb begin
        nxt_pd = pd_ff;
        if (clk_en && setup_pd_we && spi_mode) begin
            nxt_pd = setup_pd_wdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            pd_ff <= 2'h0;
        end else begin
            pd_ff <= nxt_pd;
        end
    end

    assign setup_pd = pd_ff;

    // ----------------------------------------------------------------
    // Full low power decode
    // ----------------------------------------------------------------
    // All four bits set, serial mode only
    assign full_low_power = (pd_ff == `APGC_PD_ALL) && external_clock_select
                            && external_reference_select && spi_mode;

    assign avdd_monitor_en = ~full_low_power;
    assign dvdd_monitor_en = ~full_low_power;
    assign int_ref_en      = ~full_low_power & ~external_reference_select;
    // No clock propagation; also stopped when both channels off
    assign clock_dist_en   = ~full_low_power & (pd_ff != `APGC_PD_ALL);
    assign input_clock_en  = clock_dist_en;
    assign spi_enable      = 1'b1;

    always_comb begin
        if (full_low_power) begin
            power_mode = APGC_FULL_OFF;
        end else if (pd_ff != 2'h0) begin
            power_mode = APGC_PART_OFF;
        end else begin
            power_mode = APGC_RUN;
        end
    end

    // ----------------------------------------------------------------
    // Master and sample clock dividers
    // ----------------------------------------------------------------
    logic [7:0] mdiv_ff, nxt_mdiv;
    logic [3:0] sdiv_ff, nxt_sdiv;
    logic       mtick_ff, nxt_mtick;
    logic       stick_ff, nxt_stick;

    always_comb begin
        nxt_mdiv  = mdiv_ff;
        nxt_sdiv  = sdiv_ff;
        nxt_mtick = 1'b0;
        nxt_stick = 1'b0;
        if (!clk_en) begin
            nxt_mtick = mtick_ff;
            nxt_stick = stick_ff;
        end else if (!clock_dist_en) begin
            nxt_mdiv = 8'h00;
            nxt_sdiv = 4'h0;
        end else if (mdiv_ff == 8'(MCLK_DIV - 1)) begin
            nxt_mdiv  = 8'h00;
            nxt_mtick = 1'b1;
            // Sample clock is master clock over four
            if (sdiv_ff == 4'(SMP_DIV - 1)) begin
                nxt_sdiv  = 4'h0;
                nxt_stick = 1'b1;
            end else begin
                nxt_sdiv = sdiv_ff + 4'h1;
            end
        end else begin
            nxt_mdiv = mdiv_ff + 8'h01;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            mdiv_ff  <= 8'h00;
            sdiv_ff  <= 4'h0;
            mtick_ff <= 1'b0;
            stick_ff <= 1'b0;
        end else begin
            mdiv_ff  <= nxt_mdiv;
            sdiv_ff  <= nxt_sdiv;
            mtick_ff <= nxt_mtick;
            stick_ff <= nxt_stick;
        end
    end

    assign mclk_tick              = mtick_ff;
    assign modulator_sample_clock = stick_ff;

    // ----------------------------------------------------------------
    // Channels
    // ----------------------------------------------------------------
    // Each converter held off by its own bit
    apgc_chan #(.DATA_W(DATA_W)) u_ch0 (
        .ref_clk             (ref_clk),
        .resetn              (resetn),
        .clk_en              (clk_en),
        .power_down          (pd_ff[0]),
        .channel_gain_select (channel_gain_select_0),
        .sample_tick         (stick_ff),
        .comp_in             (comp_in_0),
        .result_in           (result_in_0),
        .result_valid        (result_valid_0),
        .chan_enable         (chan_enable[0]),
        .gain_log2           (gain_log2_0),
        .therm_code          (therm_code_0),
        .dac_level           (dac_level_0),
        .data_out            (data_out_0),
        .data_ready          (data_ready[0])
    );

    apgc_chan #(.DATA_W(DATA_W)) u_ch1 (
        .ref_clk             (ref_clk),
        .resetn              (resetn),
        .clk_en              (clk_en),
        .power_down          (pd_ff[1]),
        .channel_gain_select (channel_gain_select_1),
        .sample_tick         (stick_ff),
        .comp_in             (comp_in_1),
        .result_in           (result_in_1),
        .result_valid        (result_valid_1),
        .chan_enable         (chan_enable[1]),
        .gain_log2           (gain_log2_1),
        .therm_code          (therm_code_1),
        .dac_level           (dac_level_1),
        .data_out            (data_out_1),
        .data_ready          (data_ready[1])
    );
endmodule : apgc_top

// File: verification/apgc_checker.sv
// Port checker for the power mode and gain control top.
// Assumes bind onto apgc_top, clocked by ref_clk alone.
`timescale 1ns/1ps
module apgc_checker #(
    parameter int DATA_W = 24
) (
    // Clock and control
    input wire logic                     ref_clk,
    input wire logic                     resetn,
    input wire logic                     clk_en,
    input wire logic                     spi_mode,
    input wire logic                     setup_pd_we,
    input wire logic [1:0]               setup_pd_wdata,
    input wire logic                     external_clock_select,
    input wire logic                     external_reference_select,
    input wire apgc_pkg::apgc_gain_sel_t channel_gain_select_0,
    input wire logic                     result_valid_0,
    // Watched outputs
    input wire logic                     full_low_power,
    input wire logic                     avdd_monitor_en,
    input wire logic                     dvdd_monitor_en,
    input wire logic                     int_ref_en,
    input wire logic                     clock_dist_en,
    input wire logic                     input_clock_en,
    input wire logic                     spi_enable,
    input wire logic [1:0]               setup_pd,
    input wire logic [1:0]               chan_enable,
    input wire logic                     mclk_tick,
    input wire apgc_pkg::apgc_log2_gain_t gain_log2_0,
    input wire logic [DATA_W-1:0]        data_out_0,
    input wire logic [1:0]               data_ready
);
    import apgc_pkg::*;
    // ----------------
    // Assertions
    // ----------------
    logic all_set;
    assign all_set = (setup_pd == 2'h3) && external_clock_select && external_reference_select;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    sequence s_run;
        resetn && clk_en;
    endsequence
    sequence s_take;
        s_run ##0 setup_pd_we;
    endsequence
    flp_decode_a: assert property (spi_mode |-> full_low_power == all_set)
        else $error("full low power flag wrong");
    flp_gates_a: assert property (full_low_power |-> !clock_dist_en && !input_clock_en
        && !avdd_monitor_en && !dvdd_monitor_en) else $error("gating left on");
    flp_ref_a: assert property (full_low_power |-> !int_ref_en && chan_enable == 2'h0)
        else $error("reference or channel left on");
    spi_alive_a: assert property (spi_enable)
        else $error("serial interface disabled");
    mon_back_a: assert property (!all_set |-> avdd_monitor_en && dvdd_monitor_en)
        else $error("supply monitor off");
    pd_write_a: assert property (s_take ##0 spi_mode |=>
        setup_pd == $past(setup_pd_wdata)) else $error("power-down write lost");
    pd_refuse_a: assert property (s_take ##0 !spi_mode |=>
        setup_pd == $past(setup_pd)) else $error("two-wire write taken");
    gain_map_a: assert property (s_run |=> gain_log2_0 ==
        (($past(channel_gain_select_0) > 3'h5) ? 3'h0 : $past(channel_gain_select_0)))
        else $error("gain decode wrong");
    data_off_a: assert property (s_run ##0 (result_valid_0 && setup_pd[0])
        |=> ~|data_out_0 && !data_ready[0]) else $error("data from powered-down channel");
    tick_stop_a: assert property ((!clock_dist_en && clk_en)[*2] |-> !mclk_tick)
        else $error("clock tick while stopped");
    chan_sep_a: assert property (chan_enable == ~setup_pd)
        else $error("channel enable mismatch");
    freeze_hold_a: assert property (!clk_en |=> gain_log2_0 == $past(gain_log2_0)
        && setup_pd == $past(setup_pd)) else $error("state moved while disabled");
endmodule : apgc_checker

bind apgc_top apgc_checker #(.DATA_W(DATA_W)) u_apgc_checker (.*);

// File: verification/apgc_host.sv
// Host model driving the serial setup bits.
// Assumes its tasks are called from one bench process.
`timescale 1ns/1ps
module apgc_host (
    // Clock
    input  wire logic  ref_clk,
    // Setup bits
    output logic       spi_mode,
    output logic [1:0] setup_pd_wdata,
    output logic       setup_pd_we,
    output logic       external_clock_select,
    output logic       external_reference_select
);
    // ----------------
    // Host tasks
    // ----------------
    initial begin
        spi_mode = 1'b1;
        setup_pd_wdata = 2'h0;
        setup_pd_we = 1'b0;
        external_clock_select = 1'b0;
        external_reference_select = 1'b0;
    end
    task automatic set_ctl(input logic m, input logic c, input logic r);
        @(posedge ref_clk);
        spi_mode <= m;
        external_clock_select <= c;
        external_reference_select <= r;
        #1;
    endtask : set_ctl
    task automatic write_pd(input logic [1:0] pd);
        @(posedge ref_clk);
        setup_pd_we <= 1'b1;
        setup_pd_wdata <= pd;
        @(posedge ref_clk);
        setup_pd_we <= 1'b0;
        setup_pd_wdata <= ~pd;
        #1;
    endtask : write_pd
endmodule : apgc_host

// File: verification/apgc_top_tb.sv
// Self-checking bench for the power mode and gain control top.
// Assumes a short master divider so sample pulses come quickly.
`timescale 1ns/1ps
module apgc_top_tb;
    import apgc_pkg::*;
    logic            ref_clk, resetn, clk_en, spi_mode, setup_pd_we;
    logic            external_clock_select, external_reference_select;
    logic [1:0]      setup_pd_wdata, setup_pd, chan_enable, data_ready;
    apgc_gain_sel_t  channel_gain_select_0, channel_gain_select_1;
    apgc_therm_t     comp_in_0, comp_in_1, therm_code_0, therm_code_1;
    logic [23:0]     result_in_0, result_in_1, data_out_0, data_out_1;
    logic            result_valid_0, result_valid_1, full_low_power, avdd_monitor_en;
    logic            dvdd_monitor_en, int_ref_en, clock_dist_en, input_clock_en;
    logic            spi_enable, mclk_tick, modulator_sample_clock;
    apgc_mode_t      power_mode;
    apgc_log2_gain_t gain_log2_0, gain_log2_1;
    apgc_level_t     dac_level_0, dac_level_1;
    logic [8:0]      gates;
    int              errors, cmp_count, n;
    assign gates = {full_low_power, avdd_monitor_en, dvdd_monitor_en, int_ref_en,
                    clock_dist_en, input_clock_en, spi_enable, chan_enable};
    apgc_top #(.MCLK_DIV(2)) dut (.*);
    apgc_host host (.*);
    // ----------------
    // Clock, watchdog, tasks
    // ----------------
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (5000) @(posedge ref_clk);
        errors++;
        finish_test();
    end
    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : check
    task automatic finish_test();
        if (errors == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : finish_test
    task automatic push(input logic [23:0] v);
        @(posedge ref_clk);
        result_in_0 <= v;
        result_in_1 <= ~v;
        {result_valid_0, result_valid_1} <= 2'h3;
        @(posedge ref_clk);
        {result_valid_0, result_valid_1} <= 2'h0;
        result_in_0 <= ~v;
        #1;
    endtask : push
    // ----------------
    // Tests
    // ----------------
    initial begin
        {resetn, clk_en, result_valid_0, result_valid_1} = 4'h4;
        {channel_gain_select_0, channel_gain_select_1} = 6'h00;
        {comp_in_0, comp_in_1, result_in_0, result_in_1} = 56'h0;
        repeat (4) @(posedge ref_clk);
        resetn <= 1'b1;
        #1;
        check("reset state", {setup_pd, therm_code_0, dac_level_0}, 9'h01A);
        for (int i = 0; i < 8; i++) begin
            @(posedge ref_clk);
            channel_gain_select_0 <= i[2:0];
            channel_gain_select_1 <= 3'h7 - i[2:0];
            repeat (2) @(posedge ref_clk);
            #1;
            check("gain_log2_0", gain_log2_0, (i < 6) ? i : 0);
            check("gain_log2_1", gain_log2_1, (i > 1) ? 7 - i : 0);
        end
        @(posedge ref_clk);
        comp_in_0 <= 4'hF;
        comp_in_1 <= 4'h1;
        #1;
        n = 0;
        while (modulator_sample_clock !== 1'b1 && n < 999) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        n = 0;
        do begin
            @(posedge ref_clk);
            #1;
            n += (mclk_tick === 1'b1);
        end while (modulator_sample_clock !== 1'b1 && n < 9);
        check("ticks per sample", n, 4);
        @(posedge ref_clk);
        #1;
        check("therm", {therm_code_0, dac_level_0, therm_code_1, dac_level_1},
              {4'hF, 3'h4, 4'h1, 3'h1});
        host.set_ctl(1'b1, 1'b1, 1'b1);
        host.write_pd(2'h3);
        check("gates", gates, 9'h104);
        check("power_mode", power_mode, APGC_FULL_OFF);
        n = 0;
        repeat (16) begin
            @(posedge ref_clk);
            #1;
            n += (mclk_tick === 1'b1);
        end
        check("ticks stopped", n, 0);
        push(24'hA5C3E1);
        check("off data", {data_ready, data_out_0, data_out_1}, 50'h0);
        host.set_ctl(1'b1, 1'b0, 1'b1);
        check("gates", gates, 9'h0C4);
        host.set_ctl(1'b1, 1'b1, 1'b0);
        check("gates", gates, 9'h0E4);
        host.set_ctl(1'b1, 1'b1, 1'b1);
        check("gates", gates, 9'h104);
        host.write_pd(2'h2);
        check("gates", gates, 9'h0DD);
        check("power_mode", power_mode, APGC_PART_OFF);
        host.set_ctl(1'b0, 1'b1, 1'b1);
        host.write_pd(2'h3);
        check("two-wire", {setup_pd, full_low_power}, 3'h4);
        host.set_ctl(1'b1, 1'b1, 1'b1);
        push(24'h5A3C1E);
        check("on data", {data_ready, data_out_0, data_out_1},
              {2'h1, 24'h5A3C1E, 24'h0});
        @(posedge ref_clk);
        #1;
        check("ready pulse", data_ready, 2'h0);
        host.write_pd(2'h0);
        check("power_mode", power_mode, APGC_RUN);
        // Clock enable low freezes gain and setup bits
        @(posedge ref_clk);
        clk_en <= 1'b0;
        channel_gain_select_0 <= 3'h5;
        host.write_pd(2'h1);
        repeat (2) @(posedge ref_clk);
        #1;
        check("frozen", {gain_log2_0, setup_pd}, 5'h00);
        @(posedge ref_clk);
        clk_en <= 1'b1;
        repeat (2) @(posedge ref_clk);
        #1;
        check("thawed", gain_log2_0, 3'h5);
        finish_test();
    end
endmodule : apgc_top_tb
